// >>> design/sxc_map.vh
// Register map, field positions, reset values and settling-time codes for the standby and clock-out controller.
`ifndef SXC_MAP_VH
`define SXC_MAP_VH
// Word byte addresses on the register bus.
`define SXC_ADDR_STANDBY_CTRL 4'h0
`define SXC_ADDR_SYSTEM_CTRL  4'h4
`define SXC_ADDR_CLOCK_CTRL   4'h8
`define SXC_ADDR_STATUS       4'hc
// Standby control register fields.
`define SXC_SETTLE_LSB        0
`define SXC_SETTLE_MSB        2
`define SXC_BUS_HOLD_BIT      3
`define SXC_SLEEP_DEEP_BIT    7
`define SXC_STANDBY_CTRL_RST  8'h00
// System control register fields.
`define SXC_MEM_EN_BIT        0
`define SXC_NMI_EDGE_BIT      1
`define SXC_IRQ_EN_LSB        4
`define SXC_IRQ_EN_MSB        6
`define SXC_SYSTEM_CTRL_RST   8'h01
// Clock control register fields.
`define SXC_CLK_STOP_BIT      0
`define SXC_CLK_DIR_BIT       1
`define SXC_CLOCK_CTRL_RST    8'h02
// Settling-time select codes.
`define SXC_SETTLE_8K         3'h0
`define SXC_SETTLE_16K        3'h1
`define SXC_SETTLE_32K        3'h2
`define SXC_SETTLE_64K        3'h3
`define SXC_SETTLE_128K       3'h4
`define SXC_SETTLE_256K       3'h5
`define SXC_SETTLE_RSVD       3'h6
`define SXC_SETTLE_16         3'h7
// Settling wait lengths in system clock states.
`define SXC_STATES_8K         19'h02000
`define SXC_STATES_16K        19'h04000
`define SXC_STATES_32K        19'h08000
`define SXC_STATES_64K        19'h10000
`define SXC_STATES_128K       19'h20000
`define SXC_STATES_256K       19'h40000
`define SXC_STATES_16         19'h00010
// Idle level of the synchronised pins: reset, standby and NMI high, IRQs high.
`define SXC_PIN_IDLE          6'h3f
// Operating mode encodings.
`define SXC_MODE_NORMAL       3'h0
`define SXC_MODE_SLEEP        3'h1
`define SXC_MODE_SW_DEEP_POWER_DOWN_PIN_N      3'h2
`define SXC_MODE_SETTLE       3'h3
`define SXC_MODE_RESET        3'h4
`define SXC_MODE_HW_DEEP_POWER_DOWN_PIN_N      3'h5
`endif

// >>> design/sxc_settle_timer.v
// Settling-wait counter of system clock states.
`timescale 1ns/1ps
module sxc_settle_timer #(
  parameter CNT_W = 19
) (
  // Clock, reset and enable.
  input  wire             clk,
  input  wire             rst,
  input  wire             ce,
  // Control.
  input  wire             start,
  input  wire [CNT_W-1:0] length,
  // Status.
  output wire             done,
  output reg              busy_q
);

  reg [CNT_W-1:0] count_q;

  // Load the length less one on start, then count down one state per clock.
  always @(posedge clk) begin
    if (rst) begin
      count_q <= {CNT_W{1'b0}};
      busy_q  <= 1'b0;
    end else if (ce) begin
      if (start) begin
        count_q <= length - {{(CNT_W-1){1'b0}}, 1'b1};
        busy_q  <= 1'b1;
      end else if (busy_q) begin
        if (count_q == {CNT_W{1'b0}})
          busy_q <= 1'b0;
        else
          count_q <= count_q - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Done pulses on the last state of the wait.
  assign done = busy_q && (count_q == {CNT_W{1'b0}}) && !start;

endmodule // sxc_settle_timer

// >>> design/sxc_standby_ctrl.v
// Standby entry and exit sequencer with system clock output pin control.
`timescale 1ns/1ps
module sxc_standby_ctrl #(
  parameter CNT_W = 19
) (
  // Clock, reset and enable.
  input  wire       clk,
  input  wire       rst,
  input  wire       ce,
  // Wishbone slave.
  input  wire       wb_cyc_i,
  input  wire       wb_stb_i,
  input  wire       wb_we_i,
  input  wire [3:0] wb_adr_i,
  input  wire [3:0] wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg        wb_ack_o,
  // External pins, asynchronous.
  input  wire       chip_init_pin_n,
  input  wire       deep_power_down_pin_n,
  input  wire       nmi_pin,
  input  wire [2:0] irq_pin_n,
  input  wire [2:0] boot_config_pins,
  // Processor side.
  input  wire       sleep_exec,
  input  wire       bus_cycle_end,
  output reg        reset_exception,
  output reg        wake_interrupt,
  output wire       cpu_reset,
  // Oscillator and clock gating.
  output wire       osc_enable,
  output wire       chip_clock_enable,
  // Port and bus hold control.
  output wire       port_hold,
  output wire       bus_hold,
  output wire       port_float,
  output wire       memory_enable,
  output reg  [2:0] boot_config_latched,
  // System clock output pin.
  output wire       sysclk_pin_o,
  output wire       sysclk_pin_oe_n,
  // Mode observation.
  output reg  [2:0] mode_q
);

  `include "sxc_map.vh"

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  reg [5:0] pin_meta_q;
  reg [5:0] pin_sync_q;
  reg [2:0] boot_meta_q;
  reg [2:0] boot_sync_q;
  reg       nmi_prev_q;
  reg [2:0] irq_prev_n_q;

  // Two flops on every pin before any logic reads it.
  always @(posedge clk) begin
    if (rst) begin
      pin_meta_q <= `SXC_PIN_IDLE;
      pin_sync_q <= `SXC_PIN_IDLE;
    end else if (ce) begin
      pin_meta_q <= {irq_pin_n, nmi_pin, deep_power_down_pin_n, chip_init_pin_n};
      pin_sync_q <= pin_meta_q;
    end
  end

  // Boot pins get their own two flops without reset, so the capture never takes an invented level.
  always @(posedge clk) begin
    if (ce) begin
      boot_meta_q <= boot_config_pins;
      boot_sync_q <= boot_meta_q;
    end
  end

  wire       init_n  = pin_sync_q[0];
  wire       deep_power_down_pin_n_n  = pin_sync_q[1];
  wire       nmi_s   = pin_sync_q[2];
  wire [2:0] irq_n_s = pin_sync_q[5:3];

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  reg [7:0] standby_control_register;
  reg [7:0] system_control_register;
  reg [7:0] clock_divider_control_register;

  reg  [CNT_W-1:0] settle_len;
  wire             settle_done;
  wire             settle_busy;
  reg              settle_start;

  wire [2:0] osc_settle_select      = standby_control_register[`SXC_SETTLE_MSB:`SXC_SETTLE_LSB];
  wire       bus_output_hold_enable = standby_control_register[`SXC_BUS_HOLD_BIT];
  wire       sleep_to_deep_select   = standby_control_register[`SXC_SLEEP_DEEP_BIT];
  wire       onchip_memory_enable   = system_control_register[`SXC_MEM_EN_BIT];
  wire       nmi_edge_select        = system_control_register[`SXC_NMI_EDGE_BIT];
  wire [2:0] irq_enable             = system_control_register[`SXC_IRQ_EN_MSB:`SXC_IRQ_EN_LSB];
  wire       clock_pin_stop         = clock_divider_control_register[`SXC_CLK_STOP_BIT];
  wire       clock_pin_dir          = clock_divider_control_register[`SXC_CLK_DIR_BIT];

  // Register address decode for the write path; the read path decodes wb_adr_i itself.
  function [1:0] reg_index;
    input [3:0] adr;
    begin
      case (adr)
        `SXC_ADDR_STANDBY_CTRL: reg_index = 2'h0;
        `SXC_ADDR_SYSTEM_CTRL:  reg_index = 2'h1;
        `SXC_ADDR_CLOCK_CTRL:   reg_index = 2'h2;
        default:                reg_index = 2'h3;
      endcase
    end
  endfunction

  wire       wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire       wb_write = wb_req && wb_we_i && wb_sel_i[0];
  wire [1:0] wb_idx   = reg_index(wb_adr_i);

  // One-wait-state answer; unmapped addresses read zero and ignore writes.
  always @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce) begin
      wb_ack_o <= wb_req;
      case (wb_adr_i)
        `SXC_ADDR_STANDBY_CTRL: wb_dat_o <= {24'h000000, standby_control_register};
        `SXC_ADDR_SYSTEM_CTRL:  wb_dat_o <= {24'h000000, system_control_register};
        `SXC_ADDR_CLOCK_CTRL:   wb_dat_o <= {24'h000000, clock_divider_control_register};
        `SXC_ADDR_STATUS:       wb_dat_o <= {24'h000000, 2'h0, settle_busy, init_n, deep_power_down_pin_n_n, mode_q};
        default:                wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // Control registers; hardware standby forces them to reset values.
  always @(posedge clk) begin
    if (rst || (ce && mode_q == `SXC_MODE_HW_DEEP_POWER_DOWN_PIN_N)) begin
      standby_control_register       <= `SXC_STANDBY_CTRL_RST;
      system_control_register        <= `SXC_SYSTEM_CTRL_RST;
      clock_divider_control_register <= `SXC_CLOCK_CTRL_RST;
    end else if (ce && wb_write) begin
      if (wb_idx == 2'h0)
        standby_control_register <= wb_dat_i[7:0];
      if (wb_idx == 2'h1)
        system_control_register <= wb_dat_i[7:0];
      if (wb_idx == 2'h2)
        clock_divider_control_register <= wb_dat_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settling-time select and counter.

  always @* begin
    case (osc_settle_select)
      `SXC_SETTLE_8K:   settle_len = `SXC_STATES_8K;
      `SXC_SETTLE_16K:  settle_len = `SXC_STATES_16K;
      `SXC_SETTLE_32K:  settle_len = `SXC_STATES_32K;
      `SXC_SETTLE_64K:  settle_len = `SXC_STATES_64K;
      `SXC_SETTLE_128K: settle_len = `SXC_STATES_128K;
      `SXC_SETTLE_256K: settle_len = `SXC_STATES_256K;
      `SXC_SETTLE_16:   settle_len = `SXC_STATES_16;
      default:          settle_len = `SXC_STATES_256K;
    endcase
  end

  sxc_settle_timer #(
    .CNT_W (CNT_W)
  ) u_timer (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .start  (settle_start),
    .length (settle_len),
    .done   (settle_done),
    .busy_q (settle_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wake sources.

  // NMI edge chosen by the edge select bit; IRQs are falling edges.
  always @(posedge clk) begin
    if (rst) begin
      nmi_prev_q   <= 1'b1;
      irq_prev_n_q <= 3'h7;
    end else if (ce) begin
      nmi_prev_q   <= nmi_s;
      irq_prev_n_q <= irq_n_s;
    end
  end

  wire nmi_event = nmi_edge_select ? (nmi_s && !nmi_prev_q) : (!nmi_s && nmi_prev_q);
  wire irq_event = |(irq_enable & irq_prev_n_q & ~irq_n_s);

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencer.

  reg [2:0] mode_d;

  always @* begin
    mode_d       = mode_q;
    settle_start = 1'b0;
    if (!deep_power_down_pin_n_n) begin
      mode_d = `SXC_MODE_HW_DEEP_POWER_DOWN_PIN_N;
    end else begin
      case (mode_q)
        `SXC_MODE_NORMAL: begin
          if (!init_n)
            mode_d = `SXC_MODE_RESET;
          else if (sleep_exec)
            mode_d = sleep_to_deep_select ? `SXC_MODE_SW_DEEP_POWER_DOWN_PIN_N : `SXC_MODE_SLEEP;
        end
        `SXC_MODE_SLEEP: begin
          if (!init_n)
            mode_d = `SXC_MODE_RESET;
          else if (nmi_event || irq_event)
            mode_d = `SXC_MODE_NORMAL;
        end
        `SXC_MODE_SW_DEEP_POWER_DOWN_PIN_N: begin
          if (!init_n) begin
            mode_d = `SXC_MODE_RESET;
          end else if (nmi_event || irq_event) begin
            mode_d       = `SXC_MODE_SETTLE;
            settle_start = 1'b1;
          end
        end
        `SXC_MODE_SETTLE: begin
          if (!init_n)
            mode_d = `SXC_MODE_RESET;
          else if (settle_done)
            mode_d = `SXC_MODE_NORMAL;
        end
        `SXC_MODE_RESET: begin
          if (init_n)
            mode_d = `SXC_MODE_NORMAL;
        end
        `SXC_MODE_HW_DEEP_POWER_DOWN_PIN_N: begin
          mode_d = init_n ? `SXC_MODE_NORMAL : `SXC_MODE_RESET;
        end
        default: mode_d = `SXC_MODE_RESET;
      endcase
    end
  end

  // Mode register and one-cycle exception pulses.
  always @(posedge clk) begin
    if (rst) begin
      mode_q          <= `SXC_MODE_RESET;
      reset_exception <= 1'b0;
      wake_interrupt  <= 1'b0;
    end else if (ce) begin
      mode_q          <= mode_d;
      reset_exception <= (mode_q == `SXC_MODE_RESET || mode_q == `SXC_MODE_HW_DEEP_POWER_DOWN_PIN_N) &&
                         mode_d == `SXC_MODE_NORMAL;
      wake_interrupt  <= (mode_q == `SXC_MODE_SETTLE && mode_d == `SXC_MODE_NORMAL) ||
                         (mode_q == `SXC_MODE_SLEEP && mode_d == `SXC_MODE_NORMAL);
    end
  end

  // Boot pins captured while the chip is held in reset.
  always @(posedge clk) begin
    if (rst) begin
      boot_config_latched <= 3'h0;
    end else if (ce && mode_q == `SXC_MODE_RESET) begin
      boot_config_latched <= boot_sync_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator, clock gating and port control.

  wire in_sw = (mode_q == `SXC_MODE_SW_DEEP_POWER_DOWN_PIN_N);
  wire in_hw = (mode_q == `SXC_MODE_HW_DEEP_POWER_DOWN_PIN_N);

  assign osc_enable        = !in_sw && !in_hw;
  assign chip_clock_enable = osc_enable && (mode_q != `SXC_MODE_SETTLE);
  assign cpu_reset         = (mode_q == `SXC_MODE_RESET) || in_hw;
  assign port_hold         = in_sw;
  assign bus_hold          = in_sw && bus_output_hold_enable;
  assign port_float        = in_hw;
  assign memory_enable     = onchip_memory_enable && !in_hw;

  ////////////////////////////////////////////////////////////////////////////
  // System clock output pin.

  reg clk_stopped_q;
  reg clk_toggle_q;

  always @(posedge clk) begin
    if (rst) begin
      clk_stopped_q <= 1'b0;
      clk_toggle_q  <= 1'b0;
    end else if (ce) begin
      clk_toggle_q <= ~clk_toggle_q;
      if (!clock_pin_stop)
        clk_stopped_q <= 1'b0;
      else if (bus_cycle_end)
        clk_stopped_q <= 1'b1;
    end
  end

  assign sysclk_pin_oe_n = !clock_pin_dir || in_hw;
  assign sysclk_pin_o    = (in_sw || clk_stopped_q || mode_q == `SXC_MODE_SETTLE) ? 1'b1 : clk_toggle_q;

endmodule // sxc_standby_ctrl

// >>> verif/sxc_chk.sv
// Assertion checker for the standby and clock-out controller.
`timescale 1ns/1ps
module sxc_chk #(
  parameter CNT_W = 19
) (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       rst,
  // Pins.
  input wire logic       chip_init_pin_n,
  input wire logic       deep_power_down_pin_n,
  // Outputs watched.
  input wire logic       reset_exception,
  input wire logic       wake_interrupt,
  input wire logic       cpu_reset,
  input wire logic       osc_enable,
  input wire logic       chip_clock_enable,
  input wire logic       port_hold,
  input wire logic       port_float,
  input wire logic       sysclk_pin_oe_n,
  input wire logic [2:0] mode_q
);
  // All checks run on the system clock and stop during reset.
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  AST_HW_ENTRY: assert property ($fell(deep_power_down_pin_n) |-> ##[1:4] mode_q == 3'h5)
    else $error("standby pin low did not reach hardware standby");
  AST_HW_OUTPUTS: assert property (mode_q == 3'h5 |-> port_float && cpu_reset && !osc_enable && sysclk_pin_oe_n)
    else $error("hardware standby outputs wrong");
  AST_SW_OUTPUTS: assert property (mode_q == 3'h2 |-> port_hold && !osc_enable && !chip_clock_enable)
    else $error("software standby outputs wrong");
  AST_RESET_WAKE: assert property ($fell(chip_init_pin_n) && mode_q == 3'h2 |-> ##[1:4] mode_q == 3'h4 && chip_clock_enable)
    else $error("reset pin did not restart clocks");
  AST_RESET_EXC: assert property (mode_q == 3'h0 && $past(mode_q) == 3'h4 |-> reset_exception)
    else $error("reset exception pulse missing");
  AST_HW_EXIT: assert property ($rose(deep_power_down_pin_n) && !chip_init_pin_n |-> ##[1:4] mode_q == 3'h4)
    else $error("standby release did not enter reset");
  AST_WAKE_EXC: assert property (mode_q == 3'h0 && $past(mode_q) == 3'h3 |-> wake_interrupt)
    else $error("interrupt handling pulse missing");
  AST_SETTLE_GATE: assert property (mode_q == 3'h3 |-> !chip_clock_enable && osc_enable)
    else $error("clocks not gated while settling");
endmodule // sxc_chk

bind sxc_standby_ctrl sxc_chk #(.CNT_W(CNT_W)) u_chk (.clk, .rst, .chip_init_pin_n, .deep_power_down_pin_n,
  .reset_exception, .wake_interrupt, .cpu_reset, .osc_enable, .chip_clock_enable, .port_hold, .port_float,
  .sysclk_pin_oe_n, .mode_q);

// >>> verif/sxc_supervisor.sv
// Model of the supervisor logic that drives the reset and standby pins.
`timescale 1ns/1ps
module sxc_supervisor #(
  parameter SETTLE = 20,
  parameter BOOT   = 3'h5
) (
  // System clock.
  input  wire logic       clk,
  // Pins driven into the controller.
  output logic            chip_init_pin_n,
  output logic            deep_power_down_pin_n,
  output wire logic [2:0] boot_config_pins
);
  // Both pins start released.
  initial begin
    chip_init_pin_n = 1'b1;
    deep_power_down_pin_n = 1'b1;
  end
  assign boot_config_pins = BOOT;
  // Drives the reset pin low.
  task assert_reset;
    @(posedge clk);
    chip_init_pin_n <= 1'b0;
  endtask
  task enter_hw_standby;
    repeat (4) @(posedge clk);
    deep_power_down_pin_n <= 1'b0;
  endtask
  // Releases the standby pin while reset stays low.
  task leave_hw_standby;
    @(posedge clk);
    deep_power_down_pin_n <= 1'b1;
  endtask
  task release_reset;
    repeat (SETTLE) @(posedge clk);
    chip_init_pin_n <= 1'b1;
  endtask
endmodule // sxc_supervisor

// >>> verif/sxc_standby_ctrl_tb.sv
// Self-checking testbench of the standby and clock-out controller.
`timescale 1ns/1ps
`include "sxc_map.vh"
module sxc_standby_ctrl_tb;
  typedef struct packed {logic [3:0] a; logic [3:0] s; logic [31:0] d; logic [31:0] e;} sxc_row_t;
  logic        clk = 1'b0, rst = 1'b1, req = 1'b0, we = 1'b0, slp = 1'b0, bce = 1'b0, nmi = 1'b1;
  logic [3:0]  adr = 4'h0, sel = 4'hf;
  logic [2:0]  irq_n = 3'h7;
  logic [2:0]  wcode [3] = '{3'h7, 3'h0, 3'h1};
  logic [31:0] wdat = 32'h0, rdat;
  wire  [31:0] dat_o;
  wire  [2:0]  mode_q, boot, boot_l;
  wire         ack, rexc, wake, cpu_rst, osc_en, clk_en, p_hold, b_hold, p_float, mem_en, pin_o, pin_oe_n;
  wire         init_n, dpd_n;
  int          num_errors = 0, checks = 0, n;
  sxc_row_t    rows [6] = '{'{4'h0, 4'hf, 32'h87, 32'h87}, '{4'h0, 4'he, 32'h00, 32'h87},
    '{4'h4, 4'hf, 32'h71, 32'h71}, '{4'h8, 4'hf, 32'h02, 32'h02}, '{4'h1, 4'hf, 32'hff, 32'h00},
    '{4'hc, 4'hf, 32'hff, 32'h18}};
  // Device, with only the settle code shortening long waits.
  sxc_standby_ctrl u_sxc_standby_ctrl (.clk(clk), .rst(rst), .ce(1'b1), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .chip_init_pin_n(init_n), .deep_power_down_pin_n(dpd_n), .nmi_pin(nmi), .irq_pin_n(irq_n),
    .boot_config_pins(boot), .sleep_exec(slp), .bus_cycle_end(bce), .reset_exception(rexc),
    .wake_interrupt(wake), .cpu_reset(cpu_rst), .osc_enable(osc_en), .chip_clock_enable(clk_en),
    .port_hold(p_hold), .bus_hold(b_hold), .port_float(p_float), .memory_enable(mem_en),
    .boot_config_latched(boot_l), .sysclk_pin_o(pin_o), .sysclk_pin_oe_n(pin_oe_n), .mode_q(mode_q));
  sxc_supervisor u_sup (.clk(clk), .chip_init_pin_n(init_n), .deep_power_down_pin_n(dpd_n),
    .boot_config_pins(boot));
  // 200 MHz system clock.
  always #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops.
  task complete_run;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Compares one value and reports a mismatch.
  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // A wait that ran out ends the run.
  task hang(input string what);
    num_errors++;
    $display("ERROR %0t timeout %s", $time, what);
    complete_run();
  endtask
  // One classic bus cycle, held until ack is sampled high.
  task wb_xfer(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
    int k;
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) hang("bus");
    rdat = dat_o;
    req <= 1'b0;
    we <= 1'b0;
  endtask
  // Reads one register and compares it.
  task rd_chk(input logic [3:0] a, input logic [31:0] e);
    wb_xfer(1'b0, a, 4'hf, 32'h0);
    check(rdat, e, "read");
  endtask
  // Waits for a mode under a bound.
  task wait_mode(input logic [2:0] m, input int lim);
    int k;
    k = 0;
    while (mode_q !== m && k < lim) begin
      @(posedge clk);
      k++;
    end
    if (k >= lim) hang("mode");
  endtask
  // Runs the sleep instruction and waits for the mode it leads to.
  task sleep_now(input logic [2:0] m);
    @(posedge clk);
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    wait_mode(m, 20);
  endtask
  // Clock pin must change between two samples while driven.
  task toggles;
    @(posedge clk);
    n = pin_o;
    @(posedge clk);
    check(32'({pin_o ^ n[0], pin_oe_n}), 32'h2, "clock output");
  endtask
  // Main sequence.
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      wb_xfer(1'b1, `SXC_ADDR_STANDBY_CTRL, 4'hf, 32'(c));
      rd_chk(`SXC_ADDR_STANDBY_CTRL, 32'(c));
    end
    foreach (rows[i]) begin
      wb_xfer(1'b1, rows[i].a, rows[i].s, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    $display("register table done");
    foreach (wcode[i]) begin
      wb_xfer(1'b1, `SXC_ADDR_STANDBY_CTRL, 4'hf, {24'h0, 5'h10, wcode[i]});
      sleep_now(`SXC_MODE_SW_DEEP_POWER_DOWN_PIN_N);
      check(32'({p_hold, b_hold, osc_en, clk_en, pin_o, pin_oe_n}), 32'h22, "standby outputs");
      irq_n <= 3'h6;
      wait_mode(`SXC_MODE_SETTLE, 20);
      irq_n <= 3'h7;
      n = 0;
      while (mode_q === `SXC_MODE_SETTLE && n < 20000) begin
        @(posedge clk);
        n++;
      end
      check(n, wcode[i] > 3'h5 ? 16 : 8192 << wcode[i], "settle length");
      check(32'(wake), 32'h1, "wake pulse");
      $display("wake test code %0d done", wcode[i]);
    end
    // Sleep mode, left by a falling NMI edge.
    wb_xfer(1'b1, `SXC_ADDR_STANDBY_CTRL, 4'hf, 32'h07);
    sleep_now(`SXC_MODE_SLEEP);
    check(32'({p_hold, osc_en, clk_en}), 32'h3, "sleep outputs");
    nmi <= 1'b0;
    wait_mode(`SXC_MODE_NORMAL, 10);
    check(32'(wake), 32'h1, "sleep wake");
    nmi <= 1'b1;
    $display("sleep wake done");
    wb_xfer(1'b1, `SXC_ADDR_STANDBY_CTRL, 4'hf, 32'h8f);
    sleep_now(`SXC_MODE_SW_DEEP_POWER_DOWN_PIN_N);
    check(32'(b_hold), 32'h1, "bus hold");
    u_sup.assert_reset();
    wait_mode(`SXC_MODE_RESET, 10);
    check(32'({osc_en, clk_en}), 32'h3, "clocks in reset");
    u_sup.release_reset();
    wait_mode(`SXC_MODE_NORMAL, 10);
    check(32'(rexc), 32'h1, "reset exception");
    $display("reset pin wake done");
    wb_xfer(1'b1, `SXC_ADDR_SYSTEM_CTRL, 4'hf, 32'h0);
    u_sup.assert_reset();
    u_sup.enter_hw_standby();
    wait_mode(`SXC_MODE_HW_DEEP_POWER_DOWN_PIN_N, 10);
    check(32'({p_float, cpu_rst, osc_en, mem_en, pin_oe_n}), 32'h19, "hw standby outputs");
    rd_chk(`SXC_ADDR_STANDBY_CTRL, 32'h0);
    u_sup.leave_hw_standby();
    wait_mode(`SXC_MODE_RESET, 10);
    check(32'({osc_en, p_float}), 32'h2, "standby exit");
    u_sup.release_reset();
    wait_mode(`SXC_MODE_NORMAL, 10);
    check(32'(rexc), 32'h1, "reset exception");
    check(32'(boot_l), 32'h5, "boot pins latched");
    rd_chk(`SXC_ADDR_CLOCK_CTRL, 32'h2);
    $display("hardware standby done");
    toggles();
    wb_xfer(1'b1, `SXC_ADDR_CLOCK_CTRL, 4'hf, 32'h3);
    bce <= 1'b1;
    @(posedge clk);
    bce <= 1'b0;
    repeat (2) @(posedge clk);
    n = pin_o;
    @(posedge clk);
    check(32'({pin_o, n[0]}), 32'h3, "clock stopped");
    wb_xfer(1'b1, `SXC_ADDR_CLOCK_CTRL, 4'hf, 32'h2);
    toggles();
    wb_xfer(1'b1, `SXC_ADDR_CLOCK_CTRL, 4'hf, 32'h0);
    @(posedge clk);
    check(32'(pin_oe_n), 32'h1, "pin released");
    $display("clock pin done");
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    check(32'(mode_q), 32'h4, "reset mode");
    rd_chk(`SXC_ADDR_STANDBY_CTRL, 32'h0);
    rd_chk(`SXC_ADDR_SYSTEM_CTRL, 32'h1);
    rd_chk(`SXC_ADDR_CLOCK_CTRL, 32'h2);
    $display("second reset done");
    complete_run();
  end
endmodule // sxc_standby_ctrl_tb
